// ### src/fbrl_burst.sv
// burst read sequencer with its count and enable registers
`timescale 1ns/1ps

// What this block does
// - 8-bit read/write burst sample count at 0x4b, reset value 0x06.
// - Count register sets how many samples one burst read delivers.
// - With bit 7 of 0x30 set, a burst sends the programmed count, or 256 samples when the count is zero.
// - Sample is six data bytes plus zero, one or two status bytes.
// - Count means samples, not bytes; host multiplies by sample length.
// - With burst mode off, the count register is ignored for reads.
module fbrl_burst (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic       reg_wr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  output logic            reg_rvalid_o,
  input  wire logic       sample_valid_i,
  output logic            sample_ready_o,
  input  wire logic [47:0] sample_data_i,
  input  wire logic [1:0] status_bytes_i,
  input  wire logic [7:0] status_a_i,
  input  wire logic [7:0] status_b_i,
  input  wire logic       burst_start_i,
  input  wire logic       burst_end_i,
  input  wire logic       byte_req_i,
  output logic      [7:0] byte_o,
  output logic            byte_valid_o,
  output logic            burst_busy_o,
  output logic            burst_done_o,
  output logic            burst_en_o
);

  // ------------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------------
  logic [7:0]                 burst_sample_count;
  logic [7:0]                 fifo_ctrl;
  fbrl_pkg::fbrl_state_t      state;
  logic [3:0]                 byte_idx;
  logic [3:0]                 sample_len;
  logic [8:0]                 samples_left;
  logic [7:0]                 stat_a;
  logic [7:0]                 stat_b;
  logic                       head_valid;
  logic [fbrl_pkg::SAMPLE_W-1:0] head_data;
  logic                       head_pop;
  logic                       fifo_in_ready;
  logic                       serve;
  logic                       last_byte;
  logic [8:0]                 next_len;
  logic                       start_ok;
  logic                       finish;

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  // byte of a sample, data lsb first, then the two status bytes
  function automatic logic [7:0] pick_byte(
    input logic [fbrl_pkg::SAMPLE_W-1:0] data,
    input logic [3:0]                    idx,
    input logic [7:0]                    sa,
    input logic [7:0]                    sb
  );
    logic [7:0] b;
    b = 8'h00;
    if (idx < fbrl_pkg::DATA_BYTES) begin
      b = data[idx*8 +: 8];
    end else if (idx == fbrl_pkg::STATUS_A_IDX) begin
      b = sa;
    end else if (idx == fbrl_pkg::STATUS_B_IDX) begin
      b = sb;
    end
    return b;
  endfunction : pick_byte

  // bytes per sample: six plus the appended status count, capped at two
  function automatic logic [3:0] len_of(input logic [1:0] extra);
    logic [1:0] e;
    e = (extra > fbrl_pkg::MAX_STATUS_BYTES) ? fbrl_pkg::MAX_STATUS_BYTES
                                             : extra;
    return 4'(fbrl_pkg::DATA_BYTES + {2'h0, e});
  endfunction : len_of

  // ------------------------------------------------------------------
  // register file
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      burst_sample_count <= fbrl_pkg::BURST_COUNT_RST;
    end else if (reg_wr_i && reg_addr_i == fbrl_pkg::ADDR_BURST_COUNT) begin
      burst_sample_count <= reg_wdata_i;
    end
  end

  // all eight bits kept so a read returns what was written
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      fifo_ctrl <= fbrl_pkg::FIFO_CTRL_RST;
    end else if (reg_wr_i && reg_addr_i == fbrl_pkg::ADDR_FIFO_CTRL) begin
      fifo_ctrl <= reg_wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
    end
  end

  // read data holds between reads
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        fbrl_pkg::ADDR_BURST_COUNT: reg_rdata_o <= burst_sample_count;
        fbrl_pkg::ADDR_FIFO_CTRL:   reg_rdata_o <= fifo_ctrl;
        default:                    reg_rdata_o <= fbrl_pkg::UNMAPPED_RDATA;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      burst_en_o <= 1'b0;
    end else begin
      burst_en_o <= fifo_ctrl[fbrl_pkg::BURST_EN_BIT];
    end
  end

  // ------------------------------------------------------------------
  // sample fifo
  // ------------------------------------------------------------------
  // gated by the port's own ready so a held sample is never taken twice
  fbrl_fifo #(
    .WIDTH (fbrl_pkg::SAMPLE_W),
    .DEPTH (fbrl_pkg::FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_i   (sys_clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (sample_valid_i && sample_ready_o),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (sample_data_i),
    .out_valid_o (head_valid),
    .out_ready_i (head_pop),
    .out_data_o  (head_data)
  );

  // fifo ready is already a flop; this copy is one cycle more
  // conservative, so the source may see ready late but never wrongly
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sample_ready_o <= 1'b0;
    end else begin
      sample_ready_o <= fifo_in_ready && !(sample_valid_i && sample_ready_o);
    end
  end

  // ------------------------------------------------------------------
  // burst sequencer
  // ------------------------------------------------------------------
  // a byte is served only when a sample is waiting and none is in flight
  assign serve     = (state == fbrl_pkg::FBRL_SEND) && byte_req_i &&
                     head_valid && !byte_valid_o && !burst_end_i;
  assign last_byte = byte_idx == 4'(sample_len - 1'b1);
  assign head_pop  = serve && last_byte;
  assign start_ok  = (state == fbrl_pkg::FBRL_IDLE) && burst_start_i;
  // last byte of the last sample of this burst
  assign finish    = head_pop && (samples_left == fbrl_pkg::SINGLE_SAMPLE);

  // count register only consulted in burst mode
  // a zero count asks for a full 256-sample burst
  always_comb begin
    next_len = fbrl_pkg::SINGLE_SAMPLE;
    if (fifo_ctrl[fbrl_pkg::BURST_EN_BIT]) begin
      next_len = (burst_sample_count == 8'h00) ? fbrl_pkg::ZERO_COUNT_LEN
                                               : {1'b0, burst_sample_count};
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state <= fbrl_pkg::FBRL_IDLE;
    end else begin
      case (state)
        fbrl_pkg::FBRL_IDLE: begin
          if (burst_start_i) begin
            state <= fbrl_pkg::FBRL_SEND;
          end
        end
        fbrl_pkg::FBRL_SEND: begin
          // partial sample is not popped, host sees it again next time
          if (burst_end_i || finish) begin
            state <= fbrl_pkg::FBRL_IDLE;
          end
        end
        default: state <= fbrl_pkg::FBRL_IDLE;
      endcase
    end
  end

  // byte position inside the current sample
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      byte_idx <= 4'h0;
    end else if (start_ok) begin
      byte_idx <= 4'h0;
    end else if (serve) begin
      byte_idx <= last_byte ? 4'h0 : 4'(byte_idx + 1'b1);
    end
  end

  // length frozen per burst; a change mid-burst would split a sample
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sample_len <= fbrl_pkg::DATA_BYTES;
    end else if (start_ok) begin
      sample_len <= len_of(status_bytes_i);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      samples_left <= 9'h000;
    end else if (start_ok) begin
      samples_left <= next_len;
    end else if (head_pop) begin
      samples_left <= 9'(samples_left - 1'b1);
    end
  end

  // ------------------------------------------------------------------
  // status capture
  // ------------------------------------------------------------------
  // status bytes sampled at the first byte so one sample is coherent
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      stat_a <= 8'h00;
      stat_b <= 8'h00;
    end else if (serve && byte_idx == 4'h0) begin
      stat_a <= status_a_i;
      stat_b <= status_b_i;
    end
  end

  // ------------------------------------------------------------------
  // byte output
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      byte_valid_o <= 1'b0;
    end else begin
      byte_valid_o <= serve;
    end
  end

  // byte held until the next one is served
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      byte_o <= 8'h00;
    end else if (serve) begin
      byte_o <= pick_byte(head_data, byte_idx,
                          (byte_idx == 4'h0) ? status_a_i : stat_a,
                          (byte_idx == 4'h0) ? status_b_i : stat_b);
    end
  end

  // ------------------------------------------------------------------
  // burst status
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      burst_done_o <= 1'b0;
    end else begin
      burst_done_o <= finish;
    end
  end

  // busy drops with the last byte, not a cycle later
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      burst_busy_o <= 1'b0;
    end else if (state == fbrl_pkg::FBRL_IDLE) begin
      burst_busy_o <= burst_start_i;
    end else begin
      burst_busy_o <= !(burst_end_i || finish);
    end
  end

endmodule : fbrl_burst

// ### shared/fbrl_pkg.sv
// constants shared by the burst read length block
package fbrl_pkg;

  // ------------------------------------------------------------------
  // register map
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_FIFO_CTRL   = 8'h30;
  localparam logic [7:0] ADDR_BURST_COUNT = 8'h4b;
  localparam int         BURST_EN_BIT     = 7;
  localparam logic [7:0] BURST_COUNT_RST  = 8'h06;
  localparam logic [7:0] FIFO_CTRL_RST    = 8'h00;
  localparam logic [7:0] UNMAPPED_RDATA   = 8'h00;

  // ------------------------------------------------------------------
  // sample layout
  // ------------------------------------------------------------------
  localparam int         SAMPLE_W         = 48;
  localparam int         FIFO_DEPTH       = 16;
  localparam logic [3:0] DATA_BYTES       = 4'h6;
  localparam logic [1:0] MAX_STATUS_BYTES = 2'h2;
  localparam logic [3:0] STATUS_A_IDX     = 4'h6;
  localparam logic [3:0] STATUS_B_IDX     = 4'h7;
  // a programmed count of zero reads as a full 256-sample burst
  localparam logic [8:0] ZERO_COUNT_LEN   = 9'h100;
  localparam logic [8:0] SINGLE_SAMPLE    = 9'h001;

  typedef enum logic [0:0] {
    FBRL_IDLE,
    FBRL_SEND
  } fbrl_state_t;

endpackage : fbrl_pkg

// ### src/fbrl_fifo.sv
// sample fifo with registered read data and registered flags
`timescale 1ns/1ps

module fbrl_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 16
) (
  input  wire logic             sys_clk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;

  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
  assign next_count  = (AW+1)'(count + {{AW{1'b0}}, push}
                               - {{AW{1'b0}}, pop});

  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= AW'(wr_ptr + 1'b1);
      end
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // flags come from flops so the top sees registered handshakes
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      in_ready_o  <= 1'b1;
      out_valid_o <= 1'b0;
    end else begin
      in_ready_o  <= next_count != (AW+1)'(DEPTH);
      out_valid_o <= next_count != '0;
    end
  end

  // head word prefetched; bypass when the write lands on the new head
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      out_data_o <= '0;
    end else if (push && wr_ptr == next_rd_ptr) begin
      out_data_o <= in_data_i;
    end else begin
      out_data_o <= mem[next_rd_ptr];
    end
  end

endmodule : fbrl_fifo

// ### dv/fbrl_burst_properties.sv
// port assertions for the burst read sequencer
`timescale 1ns/1ps

module fbrl_burst_properties (
  input wire logic       sys_clk_i,
  input wire logic       rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic       reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       reg_rvalid_o,
  input wire logic       burst_start_i,
  input wire logic       burst_end_i,
  input wire logic       byte_valid_o,
  input wire logic       burst_busy_o,
  input wire logic       burst_done_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  logic a4b;
  logic fresh;
  assign a4b = reg_addr_i == fbrl_pkg::ADDR_BURST_COUNT;

  // count keeps its reset value until the first write to it
  always_ff @(posedge sys_clk_i) begin
    if (rst_i)
      fresh <= 1'b1;
    else if (reg_wr_i && a4b)
      fresh <= 1'b0;
  end

  // ------------------------------------------------------------------
  // properties
  // ------------------------------------------------------------------
  a_rd_answer: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read got no answer");
  a_rd_quiet: assert property (!reg_rd_i |=> !reg_rvalid_o)
    else $error("answer without read");
  a_count_reset: assert property (reg_rd_i && a4b && fresh &&
    !reg_wr_i |=> reg_rdata_o == fbrl_pkg::BURST_COUNT_RST)
    else $error("count reset value wrong");
  a_count_rw: assert property (reg_wr_i && a4b ##1 !reg_wr_i ##1
    reg_rd_i && a4b && !reg_wr_i |=> reg_rdata_o == $past(reg_wdata_i, 3))
    else $error("count readback wrong");
  a_unmapped_zero: assert property (reg_rd_i && !a4b &&
    reg_addr_i != fbrl_pkg::ADDR_FIFO_CTRL
    |=> reg_rdata_o == fbrl_pkg::UNMAPPED_RDATA)
    else $error("unmapped read not zero");
  a_done_last: assert property (burst_done_o
    |-> byte_valid_o && !burst_busy_o)
    else $error("done not on last byte");
  a_byte_gap: assert property (byte_valid_o |=> !byte_valid_o)
    else $error("bytes back to back");
  a_byte_busy: assert property (byte_valid_o |-> $past(burst_busy_o))
    else $error("byte outside a burst");
  a_start_busy: assert property (burst_start_i && !burst_busy_o &&
    !burst_end_i |=> burst_busy_o)
    else $error("start did not open a burst");
  a_end_stops: assert property (burst_end_i && !burst_start_i
    |=> !burst_busy_o && !byte_valid_o)
    else $error("abort did not close the burst");
endmodule : fbrl_burst_properties

bind fbrl_burst fbrl_burst_properties u_props (.sys_clk_i, .rst_i,
  .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i, .reg_rdata_o,
  .reg_rvalid_o, .burst_start_i, .burst_end_i, .byte_valid_o,
  .burst_busy_o, .burst_done_o);

// ### dv/fbrl_host.sv
// host model that pulls burst bytes from the sequencer
`timescale 1ns/1ps

module fbrl_host (
  input  wire logic       sys_clk_i,
  input  wire logic [7:0] byte_o,
  input  wire logic       byte_valid_o,
  input  wire logic       burst_done_o,
  output logic            burst_start_i,
  output logic            burst_end_i,
  output logic            byte_req_i
);
  logic [7:0] got [$];
  logic       done_seen;

  initial begin
    burst_start_i = 1'b0;
    burst_end_i = 1'b0;
    byte_req_i = 1'b0;
  end

  // n counts bytes, samples times sample length for a full burst, never the raw count
  task automatic run(input int n, input int gap, input bit cut);
    got.delete();
    burst_start_i = 1'b1;
    @(posedge sys_clk_i) #1 burst_start_i = 1'b0;
    for (int i = 0; i < n; i++) begin
      byte_req_i = 1'b1;
      do @(posedge sys_clk_i) #1; while (byte_valid_o !== 1'b1);
      got.push_back(byte_o);
      done_seen = burst_done_o;
      // gap stalls the sequencer between bytes
      if (gap > 0) begin
        byte_req_i = 1'b0;
        repeat (gap) @(posedge sys_clk_i) #1;
      end
    end
    byte_req_i = 1'b0;
    // cut leaves the current sample unfinished
    if (cut) begin
      burst_end_i = 1'b1;
      @(posedge sys_clk_i) #1 burst_end_i = 1'b0;
    end
  endtask : run
endmodule : fbrl_host

// ### dv/test_fbrl_burst.sv
// self-checking bench for the burst read sequencer
`timescale 1ns/1ps

module test_fbrl_burst;
  logic        sys_clk_i, rst_i, reg_wr_i, reg_rd_i, sample_valid_i;
  logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o, byte_o;
  logic [7:0]  status_a_i, status_b_i;
  logic [47:0] sample_data_i;
  logic [1:0]  status_bytes_i;
  logic        reg_rvalid_o, sample_ready_o, burst_start_i, burst_end_i;
  logic        byte_req_i, byte_valid_o, burst_busy_o, burst_done_o;
  logic        burst_en_o;
  int          err_count, comparisons, cyc;

  fbrl_burst dut (.sys_clk_i, .rst_i, .reg_addr_i, .reg_wr_i,
    .reg_wdata_i, .reg_rd_i, .reg_rdata_o, .reg_rvalid_o,
    .sample_valid_i, .sample_ready_o, .sample_data_i, .status_bytes_i,
    .status_a_i, .status_b_i, .burst_start_i, .burst_end_i, .byte_req_i,
    .byte_o, .byte_valid_o, .burst_busy_o, .burst_done_o, .burst_en_o);
  fbrl_host host (.sys_clk_i, .byte_o, .byte_valid_o, .burst_done_o,
    .burst_start_i, .burst_end_i, .byte_req_i);

  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end

  // whole run needs well under two thousand cycles
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc > 5000) begin
      err_count++;
      end_sim();
    end
  end

  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task automatic end_sim();
    $display("counts: %0d mismatches, %0d compares", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [7:0] e, g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(posedge sys_clk_i) #1 reg_wr_i = 1'b0;
    @(posedge sys_clk_i) #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, e, input string nm);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(posedge sys_clk_i) #1 reg_rd_i = 1'b0;
    chk(nm, e, reg_rdata_o);
    @(posedge sys_clk_i) #1;
  endtask : rd

  function automatic logic [7:0] eb(input int k, input int j);
    if (j == 6)
      return status_a_i;
    if (j == 7)
      return status_b_i;
    return {k[3:0], j[3:0]};
  endfunction : eb

  task automatic push(input int k);
    for (int j = 0; j < 6; j++)
      sample_data_i[8*j+:8] = eb(k, j);
    sample_valid_i = 1'b1;
    while (sample_ready_o !== 1'b1) @(posedge sys_clk_i) #1;
    @(posedge sys_clk_i) #1 sample_valid_i = 1'b0;
    @(posedge sys_clk_i) #1;
  endtask : push

  task automatic bcheck(input int k, n, len, gap, input string nm);
    host.run(n * len, gap, 1'b0);
    for (int i = 0; i < n * len; i++)
      chk(nm, eb(k + i / len, i % len), host.got[i]);
    chk("done", 8'h01, {7'h00, host.done_seen});
    chk("busy", 8'h00, {7'h00, burst_busy_o});
    $display("test %s finished", nm);
  endtask : bcheck

  // ------------------------------------------------------------------
  // tests
  // ------------------------------------------------------------------
  initial begin
    rst_i = 1'b1;
    {reg_wr_i, reg_rd_i, sample_valid_i} = 3'h0;
    {reg_addr_i, reg_wdata_i, sample_data_i} = 64'h0;
    {status_a_i, status_b_i, status_bytes_i} = 18'h2a53c;
    repeat (8) @(posedge sys_clk_i) #1;
    rst_i = 1'b0;
    rd(fbrl_pkg::ADDR_BURST_COUNT, fbrl_pkg::BURST_COUNT_RST, "cnt");
    rd(fbrl_pkg::ADDR_FIFO_CTRL, fbrl_pkg::FIFO_CTRL_RST, "ctrl");
    rd(8'h55, fbrl_pkg::UNMAPPED_RDATA, "unmapped");
    wr(8'h55, 8'hff);
    rd(fbrl_pkg::ADDR_BURST_COUNT, fbrl_pkg::BURST_COUNT_RST, "cnt");
    wr(fbrl_pkg::ADDR_BURST_COUNT, 8'h02);
    rd(fbrl_pkg::ADDR_BURST_COUNT, 8'h02, "cnt_rw");
    $display("test registers finished");
    wr(fbrl_pkg::ADDR_FIFO_CTRL, 8'h80);
    repeat (2) @(posedge sys_clk_i) #1;
    chk("burst_en", 8'h01, {7'h00, burst_en_o});
    status_bytes_i = 2'h1;
    for (int k = 0; k < 3; k++)
      push(k);
    bcheck(0, 2, 7, 0, "burst");
    wr(fbrl_pkg::ADDR_FIFO_CTRL, 8'h00);
    status_bytes_i = 2'h0;
    host.run(3, 0, 1'b1);
    chk("cut", eb(2, 0), host.got[0]);
    chk("cut_done", 8'h00, {7'h00, host.done_seen});
    chk("cut_busy", 8'h00, {7'h00, burst_busy_o});
    $display("test cut finished");
    bcheck(2, 1, 6, 1, "single");
    wr(fbrl_pkg::ADDR_BURST_COUNT, 8'h10);
    wr(fbrl_pkg::ADDR_FIFO_CTRL, 8'h80);
    // three asks for more status bytes than exist; capped at two
    status_bytes_i = 2'h3;
    for (int k = 0; k < 16; k++)
      push(k);
    repeat (3) @(posedge sys_clk_i) #1;
    chk("full_ready", 8'h00, {7'h00, sample_ready_o});
    bcheck(0, 16, 8, 2, "fill");
    repeat (3) @(posedge sys_clk_i) #1;
    chk("empty_ready", 8'h01, {7'h00, sample_ready_o});
    end_sim();
  end
endmodule : test_fbrl_burst
